// [rtl/qdcd_top.sv]
// quad converter command decoder: decodes 24-bit serial frames into
// channel buffers, channel outputs, power-down states and reference mode.
// assumes an Avalon-MM master on clk_in and a host driving the serial pins.
//
// Notes on behaviour
// - pd flag with zero load and pd bits and bits 13:12 = 10 turns the reference off for good.
// - once off for good, data writes and loads leave the reference off until a new mode or reset.
// - load 11 with select 10 and pd clear writes the data to all buffers and loads all outputs.
// - all output changes of a frame happen together at its 24th falling clock edge.
// - pd flag with zero load and pd bits and bits 13:12 = 00 restores default reference mode, as reset does.
// - load 11, select 10, pd flag and pd bits 11 put all four outputs in high impedance.
// - in default mode the reference turns off once every channel is powered down.
// - in default mode the reference turns on when any channel returns to normal by a data write.
// - load 01, select 00, pd clear writes and loads channel A alone, others keep their state.
// - with the pd flag set, bits 15:14 pick 1k, 100k or high impedance for the channel.
// - load 10 writes the buffer and loads every channel; load 00 writes the buffer only.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "qdcd_defines.svh"

module qdcd_top (
    // clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          rstn_in,
    // avalon-mm slave
    input  wire logic [`QDCD_ADDR_W-1:0]       avs_address_in,
    input  wire logic                          avs_read_in,
    input  wire logic                          avs_write_in,
    input  wire logic [31:0]                   avs_writedata_in,
    output logic      [31:0]                   avs_readdata_out,
    output logic                               avs_waitrequest_out,
    // serial pins
    input  wire logic                          sync_n_in,
    input  wire logic                          sclk_in,
    input  wire logic                          din_in,
    // converter side
    output wire qdcd_pkg::qdcd_chan_type [3:0] chan_out,
    output logic                               ref_on_out,
    output qdcd_pkg::qdcd_ref_type             ref_mode_out
);

    // ****************************************************************
    // frame receiver
    // ****************************************************************
    qdcd_pkg::qdcd_frame_type frame;
    logic                     frame_valid;

    qdcd_serial_rx u_rx (
        .clk_in          (clk_in),
        .rstn_in         (rstn_in),
        .sync_n_in       (sync_n_in),
        .sclk_in         (sclk_in),
        .din_in          (din_in),
        .frame_out       (frame),
        .frame_valid_out (frame_valid)
    );

    // ****************************************************************
    // frame decode
    // ****************************************************************
    logic [1:0] dev_addr_reg;
    logic       hit;
    logic       ref_cmd;
    logic [1:0] pd_bits;
    logic [1:0] ref_bits;

    assign hit      = frame_valid && (frame.addr == dev_addr_reg);
    assign pd_bits  = frame.payload[`QDCD_PDBITS_MSB:`QDCD_PDBITS_LSB];
    assign ref_bits = frame.payload[`QDCD_REFBITS_MSB:`QDCD_REFBITS_LSB];
    assign ref_cmd  = frame.pd_flag && frame.load == `QDCD_LOAD_BUF_ONLY
                      && pd_bits == `QDCD_PD_NORMAL;

    // ****************************************************************
    // per-channel buffer and output
    // ****************************************************************
    logic [3:0] down_next;

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1)
        begin : g_chan
            qdcd_pkg::qdcd_chan_type buf_reg;
            qdcd_pkg::qdcd_chan_type buf_next;
            qdcd_pkg::qdcd_chan_type act_reg;
            qdcd_pkg::qdcd_chan_type act_next;
            logic                    wr;
            logic                    ld;

            // load 10 loads all, load 00 none
            // load 01 loads only the addressed one
            always_comb
            begin
                wr = hit && !ref_cmd && (frame.load == `QDCD_LOAD_BROADCAST
                     || frame.sel == 2'(ch));
                ld = hit && !ref_cmd && (frame.load[1]
                     || (frame.load == `QDCD_LOAD_SINGLE && frame.sel == 2'(ch)));
                buf_next = buf_reg;
                act_next = act_reg;
                if (wr)
                begin
                    // pd bits select the off state, code is kept
                    // pd bits 11 give high impedance
                    if (frame.pd_flag)
                        buf_next.pd = pd_bits;
                    else
                        buf_next = {`QDCD_PD_NORMAL,
                                    frame.payload[`QDCD_DATA_MSB:`QDCD_DATA_LSB]};
                end
                // every load of the frame lands in the same cycle
                if (ld)
                    act_next = buf_next;
                down_next[ch] = (act_next.pd != `QDCD_PD_NORMAL);
            end

            // power-on state is zero code, normal power
            always_ff @(posedge clk_in)
            begin
                if (!rstn_in)
                begin
                    buf_reg <= {`QDCD_PD_NORMAL, `QDCD_CODE_RESET};
                    act_reg <= {`QDCD_PD_NORMAL, `QDCD_CODE_RESET};
                end
                else
                begin
                    buf_reg <= buf_next;
                    act_reg <= act_next;
                end
            end

            assign chan_out[ch] = act_reg;
        end
    endgenerate

    // ****************************************************************
    // reference control
    // ****************************************************************
    qdcd_pkg::qdcd_ref_type mode_next;
    logic                   ref_on_next;

    always_comb
    begin
        mode_next = ref_mode_out;
        if (hit && ref_cmd)
        begin
            unique case (ref_bits)
                `QDCD_REFCMD_DEFAULT: mode_next = qdcd_pkg::REF_DEFAULT;
                `QDCD_REFCMD_ON:      mode_next = qdcd_pkg::REF_ALWAYS_ON;
                `QDCD_REFCMD_OFF:     mode_next = qdcd_pkg::REF_ALWAYS_OFF;
                default:              mode_next = ref_mode_out;
            endcase
        end
        unique case (mode_next)
            // all channels down turns it off
            // a channel back to normal turns it on
            qdcd_pkg::REF_DEFAULT:    ref_on_next = ~&down_next;
            qdcd_pkg::REF_ALWAYS_ON:  ref_on_next = 1'b1;
            qdcd_pkg::REF_ALWAYS_OFF: ref_on_next = 1'b0;
            default:                  ref_on_next = 1'b0;
        endcase
    end

    // reset gives default mode with the reference on
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            ref_mode_out <= qdcd_pkg::REF_DEFAULT;
            ref_on_out   <= 1'b1;
        end
        else
        begin
            ref_mode_out <= mode_next;
            ref_on_out   <= ref_on_next;
        end
    end

    // ****************************************************************
    // avalon-mm register slave
    // ****************************************************************
    logic        req;
    logic        wait_next;
    logic [31:0] rdata_next;
    logic [1:0]  dev_addr_next;
    logic [7:0]  frames_reg;
    logic [7:0]  frames_next;

    assign req = avs_read_in | avs_write_in;

    // one wait cycle per access keeps read data a clean flop output
    always_comb
    begin
        wait_next     = !(req && avs_waitrequest_out);
        rdata_next    = avs_readdata_out;
        dev_addr_next = dev_addr_reg;
        frames_next   = frames_reg + {7'h00, hit};
        if (avs_read_in && avs_waitrequest_out)
        begin
            unique case (avs_address_in)
                `QDCD_REG_CTRL:   rdata_next = {30'h0, dev_addr_reg};
                `QDCD_REG_STATUS: rdata_next = {16'h0, frames_reg, 5'h00,
                                                ref_on_out, ref_mode_out};
                `QDCD_REG_CHAN0:  rdata_next = {16'h0, chan_out[0]};
                `QDCD_REG_CHAN1:  rdata_next = {16'h0, chan_out[1]};
                `QDCD_REG_CHAN2:  rdata_next = {16'h0, chan_out[2]};
                `QDCD_REG_CHAN3:  rdata_next = {16'h0, chan_out[3]};
                default:          rdata_next = 32'h00000000;
            endcase
        end
        // writes take effect at the edge where waitrequest is low
        if (avs_write_in && !avs_waitrequest_out
            && avs_address_in == `QDCD_REG_CTRL)
            dev_addr_next = avs_writedata_in[1:0];
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h00000000;
            dev_addr_reg        <= `QDCD_CTRL_RESET;
            frames_reg          <= 8'h00;
        end
        else
        begin
            avs_waitrequest_out <= wait_next;
            avs_readdata_out    <= rdata_next;
            dev_addr_reg        <= dev_addr_next;
            frames_reg          <= frames_next;
        end
    end

endmodule

// [rtl/qdcd_defines.svh]
// constants of the quad converter command decoder: frame layout, codes, register map
// assumes nothing; included by the package-users by bare name
`ifndef QDCD_DEFINES_SVH
`define QDCD_DEFINES_SVH

// ****************************************************************
// serial frame
// ****************************************************************
`define QDCD_FRAME_BITS      5'h18
`define QDCD_DATA_MSB        15
`define QDCD_DATA_LSB        2
`define QDCD_PDBITS_MSB      15
`define QDCD_PDBITS_LSB      14
`define QDCD_REFBITS_MSB     13
`define QDCD_REFBITS_LSB     12

// load field codes
`define QDCD_LOAD_BUF_ONLY   2'h0
`define QDCD_LOAD_SINGLE     2'h1
`define QDCD_LOAD_ALL        2'h2
`define QDCD_LOAD_BROADCAST  2'h3
`define QDCD_SEL_BROADCAST   2'h2

// power-down codes: 00 normal, 01 1k to ground, 10 100k, 11 high impedance
`define QDCD_PD_NORMAL       2'h0
`define QDCD_PD_1K           2'h1
`define QDCD_PD_100K         2'h2
`define QDCD_PD_HIZ          2'h3

// reference command codes in frame bits thirteen and twelve
`define QDCD_REFCMD_DEFAULT  2'h0
`define QDCD_REFCMD_ON       2'h1
`define QDCD_REFCMD_OFF      2'h2

// ****************************************************************
// register map (byte addresses) and reset values
// ****************************************************************
`define QDCD_ADDR_W          5
`define QDCD_REG_CTRL        5'h00
`define QDCD_REG_STATUS      5'h04
`define QDCD_REG_CHAN0       5'h08
`define QDCD_REG_CHAN1       5'h0C
`define QDCD_REG_CHAN2       5'h10
`define QDCD_REG_CHAN3       5'h14
`define QDCD_CTRL_RESET      2'h0
`define QDCD_CODE_RESET      14'h0000

`endif

// [rtl/qdcd_pkg.sv]
// types shared by the quad converter command decoder files
// assumes nothing; widths are written as literals, not taken from qdcd_defines.svh
package qdcd_pkg;

    // one received 24-bit frame, first bit sent sits at the top
    typedef struct packed {
        logic [1:0]  addr;
        logic [1:0]  load;
        logic        spare;
        logic [1:0]  sel;
        logic        pd_flag;
        logic [15:0] payload;
    } qdcd_frame_type;

    // state of one channel: power-down code and 14-bit code
    typedef struct packed {
        logic [1:0]  pd;
        logic [13:0] code;
    } qdcd_chan_type;

    // internal reference operating mode
    typedef enum logic [1:0] {
        REF_DEFAULT,
        REF_ALWAYS_ON,
        REF_ALWAYS_OFF
    } qdcd_ref_type;

endpackage

// [rtl/qdcd_serial_rx.sv]
// serial frame receiver: synchronises select, clock and data pins and
// shifts one bit on each of the first 24 falling serial clock edges while select is low.
// assumes clk_in much faster than the serial clock (at least 4x)
`timescale 1ns/1ps
`include "qdcd_defines.svh"

module qdcd_serial_rx (
    // clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     rstn_in,
    // serial pins from the host
    input  wire logic                     sync_n_in,
    input  wire logic                     sclk_in,
    input  wire logic                     din_in,
    // received frame
    output qdcd_pkg::qdcd_frame_type      frame_out,
    output logic                          frame_valid_out
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] meta_reg;
    logic [2:0] pin_reg;
    logic       sclk_prev_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            meta_reg <= 3'h1;
            pin_reg  <= 3'h1;
        end
        else
        begin
            meta_reg <= {din_in, sclk_in, sync_n_in};
            pin_reg  <= meta_reg;
        end
    end

    // ****************************************************************
    // shift register
    // ****************************************************************
    logic [23:0] shift_reg;
    logic [23:0] shift_next;
    logic [4:0]  count_reg;
    logic [4:0]  count_next;
    logic        valid_next;
    logic        fall;

    assign fall = sclk_prev_reg & ~pin_reg[1];

    // first bit lands at the top
    always_comb
    begin
        shift_next = shift_reg;
        count_next = count_reg;
        valid_next = 1'b0;
        if (pin_reg[0])
        begin
            count_next = 5'h00;   // deselect aborts a short frame
        end
        else if (fall && count_reg != `QDCD_FRAME_BITS)
        begin
            shift_next = {shift_reg[22:0], pin_reg[2]};
            count_next = count_reg + 5'h01;
            // act at the 24th falling edge
            valid_next = (count_next == `QDCD_FRAME_BITS);
        end
    end

    // extra edges after 24 are ignored until select goes high
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            shift_reg       <= 24'h000000;
            count_reg       <= 5'h00;
            frame_valid_out <= 1'b0;
            // matches the synchroniser's reset level, so no false edge follows reset
            sclk_prev_reg   <= 1'b0;
        end
        else
        begin
            shift_reg       <= shift_next;
            count_reg       <= count_next;
            frame_valid_out <= valid_next;
            sclk_prev_reg   <= pin_reg[1];
        end
    end

    assign frame_out = qdcd_pkg::qdcd_frame_type'(shift_reg);

endmodule

// [tb/qdcd_host_model.sv]
// host serial port master: sends 24-bit frames msb first
// assumes clk_in at 10 MHz; serial clock period 8 clk (800 ns)
`timescale 1ns/1ps

module qdcd_host_model (
    // clock
    input  wire logic clk_in,
    // serial pins
    output logic      sync_n_out,
    output logic      sclk_out,
    output logic      din_out
);
    // link clock idles low so it stands still between frames
    initial
    begin
        sync_n_out = 1'b1;
        sclk_out   = 1'b0;
        din_out    = 1'b0;
    end

    // select low for every edge; nb below 24 aborts the frame
    task automatic send(input logic [23:0] f, input int nb);
        int i;
        @(posedge clk_in) sync_n_out <= 1'b0;
        for (i = 23; i > 23 - nb; i--)
        begin
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b1;
            din_out  <= f[i];
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        // select held past the update so a late decoder is caught
        repeat (8) @(posedge clk_in);
        sync_n_out <= 1'b1;
        din_out    <= ~din_out;
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// [tb/qdcd_top_assertions.sv]
// checker on the ports of the command decoder top
// assumes a host that holds select low until after each update
`timescale 1ns/1ps

module qdcd_chk (
    // clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          rstn_in,
    // bus
    input  wire logic                          avs_read_in,
    input  wire logic                          avs_write_in,
    input  wire logic [31:0]                   avs_readdata_out,
    input  wire logic                          avs_waitrequest_out,
    // serial and converter side
    input  wire logic                          sync_n_in,
    input  wire qdcd_pkg::qdcd_chan_type [3:0] chan_out,
    input  wire logic                          ref_on_out,
    input  wire qdcd_pkg::qdcd_ref_type        ref_mode_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    // all four outputs powered down
    logic all_dn;
    assign all_dn = chan_out[0].pd != 2'h0 && chan_out[1].pd != 2'h0
                 && chan_out[2].pd != 2'h0 && chan_out[3].pd != 2'h0;

    // ****************************************************************
    // properties
    // ****************************************************************
    property p_wait_one;
        !avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    property p_wait_cause;
        $fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in);
    endproperty
    property p_rdata_hold;
        $changed(avs_readdata_out) |-> $fell(avs_waitrequest_out) && $past(avs_read_in);
    endproperty
    property p_off_stays;
        ref_mode_out == qdcd_pkg::REF_ALWAYS_OFF |-> !ref_on_out;
    endproperty
    property p_on_stays;
        ref_mode_out == qdcd_pkg::REF_ALWAYS_ON |-> ref_on_out;
    endproperty
    property p_auto_ref;
        ref_mode_out == qdcd_pkg::REF_DEFAULT |-> ref_on_out == !all_dn;
    endproperty
    property p_in_frame;
        $changed(chan_out) || $changed(ref_mode_out) |-> !sync_n_in;
    endproperty
    property p_once;
        $changed(chan_out) |=> $stable(chan_out) [*8];
    endproperty
    property p_reset_state;
        $rose(rstn_in) |-> avs_waitrequest_out && chan_out == 64'h0 && ref_on_out
            && ref_mode_out == qdcd_pkg::REF_DEFAULT;
    endproperty

    a_wait_one    : assert property (p_wait_one) else $error("waitrequest low too long");
    a_wait_cause  : assert property (p_wait_cause) else $error("answer without request");
    a_rdata_hold  : assert property (p_rdata_hold) else $error("read data moved");
    a_off_stays   : assert property (p_off_stays) else $error("reference on in off mode");
    a_on_stays    : assert property (p_on_stays) else $error("reference off in on mode");
    a_auto_ref    : assert property (p_auto_ref) else $error("automatic reference wrong");
    a_in_frame    : assert property (p_in_frame) else $error("update outside frame");
    a_once        : assert property (p_once) else $error("outputs changed twice");
    a_reset_state : assert property (p_reset_state) else $error("bad reset state");

    c_read : cover property ($fell(avs_waitrequest_out) && $past(avs_read_in));
    c_off  : cover property (ref_mode_out == qdcd_pkg::REF_ALWAYS_OFF);
    c_hiz  : cover property (all_dn);
endmodule

bind qdcd_top qdcd_chk u_chk (
    .clk_in(clk_in), .rstn_in(rstn_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .sync_n_in(sync_n_in),
    .chan_out(chan_out), .ref_on_out(ref_on_out), .ref_mode_out(ref_mode_out)
);

// [tb/tb_qdcd_top.sv]
// testbench of the command decoder: bus tasks plus host frames
// assumes the host model drives the serial pins
`timescale 1ns/1ps
`include "qdcd_defines.svh"

module tb_qdcd_top;
    logic                          clk_in, rstn_in, avs_read_in, avs_write_in;
    logic                          sync_n_in, sclk_in, din_in, avs_waitrequest_out;
    logic [4:0]                    avs_address_in;
    logic [31:0]                   avs_writedata_in, avs_readdata_out, rd;
    qdcd_pkg::qdcd_chan_type [3:0] chan_out;
    logic                          ref_on_out, eon;
    qdcd_pkg::qdcd_ref_type        ref_mode_out;
    logic [15:0]                   ec [4];
    logic [1:0]                    emd;
    int                            miscompares, n_tests, acc;

    qdcd_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .sync_n_in(sync_n_in),
        .sclk_in(sclk_in), .din_in(din_in), .chan_out(chan_out),
        .ref_on_out(ref_on_out), .ref_mode_out(ref_mode_out));
    qdcd_host_model u_host (.clk_in(clk_in), .sync_n_out(sync_n_in),
        .sclk_out(sclk_in), .din_out(din_in));

    // 10 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] wd);
        @(posedge clk_in);
        avs_address_in   <= a;
        avs_writedata_in <= wd;
        avs_read_in      <= !wr;
        avs_write_in     <= wr;
        // no cycle limit here: only the watchdog ends a hung access
        do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_read_in  <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    function automatic logic [23:0] fr(input logic [1:0] ad, ld, sl, input logic pd,
                                       input logic [15:0] pl);
        return {ad, ld, 1'b0, sl, pd, pl};
    endfunction

    // sends a frame, counts it if accepted, then compares the channel and reference outputs
    task automatic tx(input logic [23:0] f, input int nb, input int ok, input string nm);
        int i;
        u_host.send(f, nb);
        acc += ok;
        for (i = 0; i < 4; i++)
            check(32'(chan_out[i]), 32'(ec[i]));
        check(32'(ref_on_out), 32'(eon));
        check(32'(ref_mode_out), 32'(emd));
        $display("test %0s done", nm);
    endtask

    // watchdog well beyond the expected 2600 cycles
    initial
    begin
        #2000000;
        miscompares++;
        results();
    end

    initial
    begin
        {rstn_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
        {miscompares, n_tests, acc} = '0;
        repeat (20) @(posedge clk_in);
        rstn_in <= 1'b1;
        ec = '{4{16'h0000}};
        eon = 1'b1;
        emd = 2'h0;
        // reset state and register map, unmapped address reads zero
        bus(`QDCD_REG_STATUS, 1'b0, 32'h0);
        check(rd, 32'h4);
        bus(5'h1C, 1'b0, 32'h0);
        check(rd, 32'h0);
        $display("test reset_map done");
        // broadcast data
        ec = '{4{16'h2ABC}};
        tx(fr(2'h0, 2'h3, 2'h2, 1'b0, 16'hAAF0), 24, 1, "broadcast");
        // reference off survives a data broadcast
        emd = 2'h2;
        eon = 1'b0;
        tx(fr(2'h0, 2'h0, 2'h0, 1'b1, 16'h2000), 24, 1, "ref_off");
        ec = '{4{16'h1234}};
        tx(fr(2'h0, 2'h3, 2'h2, 1'b0, 16'h48D0), 24, 1, "off_kept");
        emd = 2'h1;
        eon = 1'b1;
        tx(fr(2'h0, 2'h0, 2'h0, 1'b1, 16'h1000), 24, 1, "ref_on");
        emd = 2'h0;
        tx(fr(2'h0, 2'h0, 2'h0, 1'b1, 16'h0000), 24, 1, "ref_default");
        // reserved reference code 11 changes nothing
        tx(fr(2'h0, 2'h0, 2'h0, 1'b1, 16'h3000), 24, 1, "ref_rsvd");
        // all high impedance, codes kept, reference drops
        ec = '{4{16'hD234}};
        eon = 1'b0;
        tx(fr(2'h0, 2'h3, 2'h2, 1'b1, 16'hC000), 24, 1, "all_hiz");
        ec[0] = 16'h3FFF;
        eon = 1'b1;
        tx(fr(2'h0, 2'h1, 2'h0, 1'b0, 16'hFFFC), 24, 1, "chan_a");
        // buffer only, then load all with 100k on channel C
        tx(fr(2'h0, 2'h0, 2'h1, 1'b1, 16'h4000), 24, 1, "buf_only");
        ec[1] = 16'h5234;
        ec[2] = 16'h9234;
        tx(fr(2'h0, 2'h2, 2'h2, 1'b1, 16'h8000), 24, 1, "load_all");
        // foreign address and aborted frame are both ignored
        tx(fr(2'h1, 2'h3, 2'h2, 1'b0, 16'h1554), 24, 0, "foreign");
        tx(fr(2'h0, 2'h3, 2'h2, 1'b0, 16'h1554), 12, 0, "abort");
        bus(`QDCD_REG_CTRL, 1'b1, 32'h1);
        bus(`QDCD_REG_CTRL, 1'b0, 32'h0);
        check(rd, 32'h1);
        ec = '{4{16'h0555}};
        tx(fr(2'h1, 2'h3, 2'h2, 1'b0, 16'h1554), 24, 1, "own_addr");
        bus(`QDCD_REG_STATUS, 1'b0, 32'h0);
        check(rd, 32'(acc << 8) | 32'h4);
        $display("test status done");
        results();
    end
endmodule
